//--- common/pdi_pkg.sv
// constants, types and records for the pump driver i2c target path
// assumes a single 20 MHz system clock and a byte-wide register bank outside
package pdi_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam logic [3:0] REG_FIRST = 4'h0;
   localparam logic [3:0] REG_LAST = 4'hB;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // arbitrary upper five address bits, straps supply the low two
   localparam logic [4:0] ADDR_BASE = 5'h0A;
   localparam int PUMP_DIV = 4;
   localparam int INT_PUMP_HZ = 200;
   localparam int INT_CLK_HZ = INT_PUMP_HZ * PUMP_DIV;
   localparam int INT_HALF_CYCLES = CLK_HZ / (2 * INT_CLK_HZ);
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_ACK = 3'h2,
      ST_RX = 3'h3,
      ST_RX_ACK = 3'h4,
      ST_TX = 3'h5,
      ST_TX_ACK = 3'h6
   } pdi_state_t;

   typedef struct packed {
      logic [3:0] index;
      logic [7:0] data;
   } pdi_wr_t;
endpackage : pdi_pkg

//--- hdl/pdi_top.sv
// i2c target read/write path of the pump driver, write fifo and pump clocks
// assumes SCL, SDA, straps and pump clock arrive asynchronously from pins;
// register contents live outside, read through RD_INDEX/RD_DATA on MCLK
`timescale 1ns/1ps
`default_nettype none

// write fifo: parameterised width and depth, valid/ready both sides
module pdi_fifo #(
   parameter int W = 12,
   parameter int D = 8
) (
   // clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;
   wire logic do_push = ce & in_valid & in_ready;
   wire logic do_pop = ce & out_valid & out_ready;

   // extra pointer bit tells full from empty
   assign in_ready = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
   assign out_valid = (wp != rp);
   assign out_data = mem[rp[AW-1:0]];

   always_ff @(posedge clk) begin
      if (do_push) mem[wp[AW-1:0]] <= in_data;
   end

   // pointer update
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (do_push) wp <= wp + 1'b1;
         if (do_pop) rp <= rp + 1'b1;
      end
   end
endmodule : pdi_fifo

// What this block does
// [RQ1] ack own address with read bit by holding data low through ninth pulse
// [RQ2] start then read address resets pointer to register zero
// [RQ3] transmit bits change on clock low so they are valid at clock rise
// [RQ4] pointer advances by one after each transmitted byte
// [RQ5] stop ends the frame; later plain read restarts at zero
// [RQ6] write address, index byte, repeated start, read returns that register first
// [RQ7] read pointer saturates at register 0x0B
// [RQ8] master acks all read bytes but the last, nacks it, then stops
// [RQ9] processor disable pin low enables i2c, high leaves stand-alone mode
// [RQ10] pump clock input divided by four; internal clock gives 200 Hz pump
// [RQ11] two straps set low address bits, four devices per bus
// [RQ12] write pointer advances per data byte and saturates at 0x0B
// [RQ13] each accepted received byte acked by holding data low ninth pulse
// [RQ14] after master nack release data line until next start
module pdi_top
   import pdi_pkg::*;
#(
   parameter int INT_HALF = INT_HALF_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   // clock, enable, reset
   input wire logic MCLK,
   input wire logic MCLK_EN,
   input wire logic RESETN,
   // i2c pins
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // mode and address straps
   input wire logic PROC_DISABLE_N,
   output logic I2C_ENABLE,
   output logic PROC_RUN,
   input wire logic BUS_ADDR_STRAP_LO,
   input wire logic BUS_ADDR_STRAP_HI,
   // register bank read port
   output logic [3:0] RD_INDEX,
   input wire logic [7:0] RD_DATA,
   // register bank write stream
   output logic WR_VALID,
   input wire logic WR_READY,
   output logic [3:0] WR_INDEX,
   output logic [7:0] WR_DATA,
   // pump clocks
   input wire logic PUMP_CLK_IN,
   output logic PUMP_CLK_INT,
   output logic PUMP_DRIVE
);
   logic [1:0] rst_ff;
   wire logic rst_n = rst_ff[1];
   wire logic ce = MCLK_EN;
   logic [5:0] sync_m;
   logic [5:0] sync_s;
   logic scl_d;
   logic sda_d;
   logic pump_d;
   logic i2c_en;
   logic [1:0] strap;
   logic [1:0] strap_wait;
   pdi_state_t state;
   logic [3:0] bitn;
   logic [7:0] sh;
   logic [7:0] txb;
   logic [3:0] ptr;
   logic rw;
   logic preset;
   logic index_phase;
   logic mack;
   logic oe;
   logic [1:0] pdiv;
   logic [15:0] icnt;
   logic pclk_int;
   logic fifo_ready;
   pdi_wr_t wr_in;
   pdi_wr_t wr_out;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) rst_ff <= 2'h0;
      else rst_ff <= {rst_ff[0], 1'b1};
   end

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         sync_m <= 6'h3F;
         sync_s <= 6'h3F;
      end else if (ce) begin
         sync_m <= {PUMP_CLK_IN, BUS_ADDR_STRAP_HI, BUS_ADDR_STRAP_LO, PROC_DISABLE_N, SDA_IN, SCL};
         sync_s <= sync_m;
      end
   end

   wire logic scl_s = sync_s[0];
   wire logic sda_s = sync_s[1];
   wire logic scl_rise = ce & scl_s & ~scl_d;
   wire logic scl_fall = ce & ~scl_s & scl_d;
   wire logic start = ce & scl_s & scl_d & sda_d & ~sda_s;
   wire logic stop = ce & scl_s & scl_d & ~sda_d & sda_s;
   wire logic byte_end = scl_fall & (bitn == BYTE_BITS);
   wire logic [6:0] my_addr = {ADDR_BASE, strap};
   wire logic addr_match = (sh[7:1] == my_addr);
   wire logic [3:0] next_ptr = (ptr == REG_LAST) ? REG_LAST : ptr + 4'h1;
   wire logic [3:0] index_sat = (sh > {4'h0, REG_LAST}) ? REG_LAST : sh[3:0];
   wire logic push = (state == ST_RX) & byte_end & ~index_phase & fifo_ready;
   wire logic [2:0] tx_sel = 3'(4'h7 - bitn);

   // delayed copies for edge finding, mode pin and strap capture
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         pump_d <= 1'b1;
         i2c_en <= 1'b0;
         strap <= 2'h0;
         strap_wait <= 2'h0;
      end else if (ce) begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         pump_d <= sync_s[5];
         i2c_en <= ~sync_s[2]; // RQ9
         // synchroniser still holds its reset ones for two edges, so keep sampling until the third
         if (strap_wait != 2'h3) begin
            strap_wait <= strap_wait + 2'h1;
            strap <= sync_s[4:3]; // RQ11
         end
      end
   end

   // byte engine; stop and mode loss always win over bit work
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bitn <= 4'h0;
         sh <= 8'h00;
         txb <= 8'h00;
         ptr <= REG_FIRST;
         rw <= 1'b0;
         preset <= 1'b0;
         index_phase <= 1'b0;
         mack <= 1'b0;
         oe <= 1'b0;
      end else if (ce) begin
         if (!i2c_en || stop) begin // RQ5 RQ9
            state <= ST_IDLE;
            oe <= 1'b0;
            preset <= 1'b0;
         end else if (start) begin
            state <= ST_ADDR;
            bitn <= 4'h0;
            oe <= 1'b0;
         end else begin
            if (scl_rise) begin
               sh <= {sh[6:0], sda_s};
               bitn <= bitn + 4'h1;
            end
            unique case (state)
               ST_IDLE: begin
               end
               ST_ADDR: if (byte_end) begin
                  if (addr_match) begin
                     oe <= 1'b1; // RQ1 RQ13
                     rw <= sh[0];
                     index_phase <= ~sh[0];
                     state <= ST_ADDR_ACK;
                     if (sh[0] && !preset) ptr <= REG_FIRST; // RQ2 RQ5
                     if (sh[0]) preset <= 1'b0; // RQ6
                  end else begin
                     state <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK, ST_RX_ACK: if (scl_fall) begin
                  bitn <= 4'h0;
                  if (rw && state == ST_ADDR_ACK) begin
                     txb <= RD_DATA;
                     oe <= ~RD_DATA[7]; // RQ3
                     state <= ST_TX;
                  end else begin
                     oe <= 1'b0;
                     state <= oe ? ST_RX : ST_IDLE;
                  end
               end
               ST_RX: if (byte_end) begin
                  index_phase <= 1'b0;
                  state <= ST_RX_ACK;
                  if (index_phase) begin
                     ptr <= index_sat; // RQ6
                     preset <= 1'b1;
                     oe <= 1'b1; // RQ13
                  end else if (fifo_ready) begin
                     ptr <= next_ptr; // RQ12
                     oe <= 1'b1; // RQ13
                  end
               end
               ST_TX: if (scl_fall) begin
                  if (bitn == BYTE_BITS) begin
                     oe <= 1'b0;
                     ptr <= next_ptr; // RQ4 RQ7
                     state <= ST_TX_ACK;
                  end else begin
                     oe <= ~txb[tx_sel]; // RQ3
                  end
               end
               ST_TX_ACK: if (scl_rise) begin
                  mack <= ~sda_s; // RQ8
               end else if (scl_fall) begin
                  bitn <= 4'h0;
                  if (mack) begin
                     txb <= RD_DATA;
                     oe <= ~RD_DATA[7];
                     state <= ST_TX;
                  end else begin
                     state <= ST_IDLE; // RQ14
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // pump clocks: external divided by four, internal from a long divider
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pdiv <= 2'h0;
         icnt <= 16'h0000;
         pclk_int <= 1'b0;
      end else if (ce) begin
         if (sync_s[5] && !pump_d) pdiv <= pdiv + 2'h1; // RQ10
         if (icnt == 16'(INT_HALF - 1)) begin
            icnt <= 16'h0000;
            pclk_int <= ~pclk_int; // RQ10
         end else begin
            icnt <= icnt + 16'h0001;
         end
      end
   end

   // write stream: a full fifo nacks the byte instead of dropping it
   assign wr_in = '{index: ptr, data: sh};
   pdi_fifo #(.W($bits(pdi_wr_t)), .D(DEPTH)) u_fifo (
      .clk(MCLK),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(wr_in),
      .out_valid(WR_VALID),
      .out_ready(WR_READY),
      .out_data(wr_out)
   );

   // output assignments; sda only ever pulls low
   assign SDA_OUT = 1'b0;
   assign SDA_OE = oe;
   assign I2C_ENABLE = i2c_en;
   assign PROC_RUN = ~i2c_en;
   assign RD_INDEX = ptr;
   assign WR_INDEX = wr_out.index;
   assign WR_DATA = wr_out.data;
   assign PUMP_DRIVE = pdiv[1];
   assign PUMP_CLK_INT = pclk_int;

   // checks on the byte engine
   property p_addr_ack;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_ADDR && byte_end && addr_match && i2c_en && !stop && !start) |=> oe && state == ST_ADDR_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // RQ1

   property p_ptr_zero;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_ADDR && byte_end && addr_match && sh[0] && !preset && i2c_en && !stop && !start) |=> ptr == 4'h0;
   endproperty
   a_ptr_zero: assert property (p_ptr_zero) else $error("plain read did not start at zero"); // RQ2

   property p_tx_bit;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_TX && scl_rise && bitn < BYTE_BITS) |-> oe == ~txb[tx_sel];
   endproperty
   a_tx_bit: assert property (p_tx_bit) else $error("data bit wrong at clock rise"); // RQ3

   property p_tx_inc;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_TX && byte_end && i2c_en && !stop && !start) |=>
         ptr == (($past(ptr) == REG_LAST) ? REG_LAST : $past(ptr) + 4'h1);
   endproperty
   a_tx_inc: assert property (p_tx_inc) else $error("read pointer did not advance"); // RQ4

   property p_stop;
      @(posedge MCLK) disable iff (!rst_n)
      stop |=> state == ST_IDLE && !oe && !preset;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not end frame"); // RQ5

   property p_preset;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_RX && byte_end && index_phase && i2c_en && !stop && !start) |=> preset && ptr == $past(index_sat);
   endproperty
   a_preset: assert property (p_preset) else $error("index byte not taken"); // RQ6

   property p_sat;
      @(posedge MCLK) disable iff (!rst_n)
      ptr <= REG_LAST;
   endproperty
   a_sat: assert property (p_sat) else $error("pointer beyond top register"); // RQ7

   property p_wr_inc;
      @(posedge MCLK) disable iff (!rst_n)
      (push && i2c_en && !stop && !start) |=> oe && ptr == (($past(ptr) == REG_LAST) ? REG_LAST : $past(ptr) + 4'h1);
   endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("write byte not acked or counted"); // RQ12 RQ13

   property p_nack;
      @(posedge MCLK) disable iff (!rst_n)
      (state == ST_TX_ACK && scl_fall && !mack) |=> !oe && state == ST_IDLE;
   endproperty
   a_nack: assert property (p_nack) else $error("line held after master nack"); // RQ14

   property p_mode;
      @(posedge MCLK) disable iff (!rst_n)
      !i2c_en |=> !oe;
   endproperty
   a_mode: assert property (p_mode) else $error("bus driven in stand-alone mode"); // RQ9
endmodule : pdi_top
`default_nettype wire

//--- sim/pdi_master.sv
// i2c bus master model: drives SCL, pulls SDA low, samples the wire
// assumes a pull-up on SDA and SCL idling high between frames
`timescale 1ns/1ps
`default_nettype none
module pdi_master (
   // clock
   input wire logic clk,
   // bus
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w

   // also serves as repeated start from SCL low
   task automatic start();
      sda_low <= 1'b0;
      // three cycles low lets the target drop its ack before SCL rises
      w(3);
      scl <= 1'b1;
      w(2);
      sda_low <= 1'b1;
      w(2);
      scl <= 1'b0;
      w(1);
   endtask : start

   task automatic stop();
      sda_low <= 1'b1;
      w(3);
      scl <= 1'b1;
      w(2);
      sda_low <= 1'b0;
      w(2);
   endtask : stop

   // 400 ns bit; data moves one cycle after the fall, never while SCL high
   task automatic bit_x(input logic b, output logic r);
      sda_low <= ~b;
      w(3);
      scl <= 1'b1;
      w(2);
      r = sda;
      w(2);
      scl <= 1'b0;
      w(1);
   endtask : bit_x

   // msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
      bit_x(ack_in, ack);
   endtask : xfer
endmodule : pdi_master
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the pump driver i2c target path
// assumes pdi_master on the bus and a stand-in register bank returning index plus a fixed offset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
$display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
   import pdi_pkg::*;
   localparam int SIM_HALF = 10;
   logic mclk, resetn, pdis_n, st_lo, st_hi, wr_ready, pump_in, a, en;
   logic [7:0] rd_data, d;
   int error_cnt, comparisons, cyc;
   wire logic scl, m_low, sda_oe, sda_out, wr_valid, i2c_en, proc_run, pump_int, pump_drv;
   wire logic [3:0] rd_index, wr_index;
   wire logic [7:0] wr_data;
   // open-drain wire with pull-up
   wire logic sda = ~m_low & (sda_oe ? sda_out : 1'b1);

   pdi_top #(.INT_HALF(SIM_HALF), .DEPTH(8)) u_pdi_top (.MCLK(mclk), .MCLK_EN(en), .RESETN(resetn),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .PROC_DISABLE_N(pdis_n), .I2C_ENABLE(i2c_en),
      .PROC_RUN(proc_run), .BUS_ADDR_STRAP_LO(st_lo), .BUS_ADDR_STRAP_HI(st_hi), .RD_INDEX(rd_index),
      .RD_DATA(rd_data), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_INDEX(wr_index), .WR_DATA(wr_data),
      .PUMP_CLK_IN(pump_in), .PUMP_CLK_INT(pump_int), .PUMP_DRIVE(pump_drv));
   pdi_master u_pdi_master (.clk(mclk), .scl(scl), .sda_low(m_low), .sda(sda));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // register bank stand-in, one cycle behind the index, well before use
   always @(posedge mclk) rd_data <= 8'hA0 + {4'h0, rd_index};
   // hang guard, runs need about 2900 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   function automatic logic [7:0] ev(input int i);
      return 8'hA0 + ((i > REG_LAST) ? {4'h0, REG_LAST} : 8'(i));
   endfunction : ev

   task automatic final_report();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic rst(input logic hi, input logic lo);
      resetn <= 1'b0;
      st_hi <= hi;
      st_lo <= lo;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask : rst

   // (repeated) start, read n bytes, nack the last, stop
   task automatic rd(input int n, input int first);
      u_pdi_master.start();
      u_pdi_master.xfer({ADDR_BASE, st_hi, st_lo, 1'b1}, 1'b1, d, a);
      `CHK("read addr ack", 1'b0, a)
      for (int i = 0; i < n; i++) begin
         u_pdi_master.xfer(8'hFF, i == n - 1, d, a);
         `CHK("read data", ev(first + i), d)
      end
      u_pdi_master.stop();
      repeat (4) @(posedge mclk);
      `CHK("sda released", 1'b0, sda_oe)
   endtask : rd

   task automatic t_mode();
      pdis_n <= 1'b1;
      rst(1'b0, 1'b1);
      `CHK("i2c enable", 1'b0, i2c_en)
      `CHK("proc run", 1'b1, proc_run)
      u_pdi_master.start();
      u_pdi_master.xfer({ADDR_BASE, 2'b01, 1'b1}, 1'b1, d, a);
      `CHK("stand-alone ack", 1'b1, a)
      u_pdi_master.stop();
      pdis_n <= 1'b0;
      repeat (6) @(posedge mclk);
      `CHK("i2c enable", 1'b1, i2c_en)
      `CHK("proc run", 1'b0, proc_run)
      u_pdi_master.start();
      u_pdi_master.xfer({ADDR_BASE, 2'b10, 1'b1}, 1'b1, d, a);
      `CHK("foreign addr ack", 1'b1, a)
      u_pdi_master.stop();
   endtask : t_mode

   task automatic t_read();
      rd(14, 0);
      rd(2, 0);
   endtask : t_read

   // other strap pair, pointer preset then repeated start
   task automatic t_preset();
      rst(1'b1, 1'b0);
      u_pdi_master.start();
      u_pdi_master.xfer({ADDR_BASE, 2'b10, 1'b0}, 1'b1, d, a);
      `CHK("write addr ack", 1'b0, a)
      u_pdi_master.xfer(8'h05, 1'b1, d, a);
      `CHK("index ack", 1'b0, a)
      rd(2, 5);
   endtask : t_preset

   // consumer stalls: eight records fit, the ninth byte is refused
   task automatic t_write();
      u_pdi_master.start();
      u_pdi_master.xfer({ADDR_BASE, st_hi, st_lo, 1'b0}, 1'b1, d, a);
      u_pdi_master.xfer(8'h0A, 1'b1, d, a);
      for (int i = 0; i < 9; i++) begin
         u_pdi_master.xfer(8'h30 + 8'(i), 1'b1, d, a);
         `CHK("data ack", i == 8, a)
      end
      u_pdi_master.stop();
      wr_ready <= 1'b1;
      // sample between edges, where the fifo head has settled
      for (int k = 0; k < 8; k++) begin
         @(negedge mclk);
         `CHK("wr valid", 1'b1, wr_valid)
         `CHK("wr index", (k == 0) ? 4'hA : REG_LAST, wr_index)
         `CHK("wr data", 8'h30 + 8'(k), wr_data)
      end
      @(negedge mclk);
      `CHK("wr drained", 1'b0, wr_valid)
      @(posedge mclk);
   endtask : t_write

   // eight input rises and a 100-cycle window on the internal clock
   task automatic t_pump();
      int nd;
      int ni;
      logic pd;
      logic pi;
      nd = 0;
      ni = 0;
      pd = pump_drv;
      pi = pump_int;
      for (int c = 0; c < 100; c++) begin
         if (c < 64 && c % 4 == 0) pump_in <= ~pump_in;
         @(posedge mclk);
         if (pump_drv !== pd) nd++;
         if (pump_int !== pi) ni++;
         pd = pump_drv;
         pi = pump_int;
      end
      `CHK("pump drive toggles", 4, nd)
      `CHK("internal clock toggles", 100 / SIM_HALF, ni)
      // enable low must freeze the internal divider for three half periods
      en <= 1'b0;
      @(posedge mclk);
      pi = pump_int;
      repeat (3 * SIM_HALF) @(posedge mclk);
      `CHK("frozen internal clock", pi, pump_int)
      en <= 1'b1;
   endtask : t_pump

   initial begin
      resetn = 1'b0;
      en = 1'b1;
      pdis_n = 1'b1;
      st_lo = 1'b0;
      st_hi = 1'b0;
      wr_ready = 1'b0;
      pump_in = 1'b0;
      rd_data = 8'h00;
      error_cnt = 0;
      comparisons = 0;
      cyc = 0;
      t_mode();
      t_read();
      t_preset();
      t_write();
      t_pump();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
